/* design/mdt_timer.v */
// Multimode delay timer core
// Summary of operation
// - On-delay: output rises when set time reached
// - On-delay: reset input clears count and output
// - Timing starts at power-up without reset input
// - Integrate: enable open holds count, then resumes
// - Integrate: output when summed intervals reach set
// - One-shot: output on start, cleared at set time
// - One-shot: reset without start aborts, clears output
// - One-shot: start ignored while timing runs
// - Off-delay: output on start; reset holds timing
// - Off-delay: start works under standing reset
// - Off-delay: timing begins at reset release
// - Internal time base counted to preset value
// - Strapped full-scale range 1s/10s/1min/10min
`timescale 1ns/1ps
`include "mdt_map.vh"

module mdt_timer #(
    parameter TICK_CYCLES = `MDT_TICK_CYCLES,
    parameter FS_1S       = `MDT_FS_1S_MS,
    parameter FS_10S      = `MDT_FS_10S_MS,
    parameter FS_1MIN     = `MDT_FS_1MIN_MS,
    parameter FS_10MIN    = `MDT_FS_10MIN_MS
) (
    input  wire                  mclk,
    input  wire                  nrst,
    input  wire                  ce,
    input  wire [1:0]            mode,
    input  wire [1:0]            range_sel,
    input  wire [`MDT_SET_W-1:0] set_permille,
    input  wire                  start_in,
    input  wire                  reset_in,
    input  wire                  run_en,
    output reg                   ctrl_out,
    output wire                  timing
);
    localparam CW = 20;
    localparam TW = 16;
    localparam PW = 30;
    // Sized copies keep compares and divides at their own width
    localparam integer TICK_LAST_I = TICK_CYCLES - 1;
    localparam integer SET_FULL_I  = `MDT_SET_FULL;
    localparam [TW-1:0] TICK_LAST  = TICK_LAST_I[TW-1:0];
    localparam [PW-1:0] SET_FULL   = SET_FULL_I[PW-1:0];

    // ===========================================================
    // States
    localparam ST_IDLE = 2'h0;
    localparam ST_RUN  = 2'h1;
    localparam ST_HOLD = 2'h2;
    localparam ST_DONE = 2'h3;

    // ===========================================================
    // Input synchronisation
    wire [2:0] sync_w;
    mdt_sync #(
        .W    (3)
    ) u_sync (
        .mclk (mclk),
        .nrst (nrst),
        .ce   (ce),
        .din  ({run_en, reset_in, start_in}),
        .dout (sync_w)
    );
    wire start_s = sync_w[0];
    wire rst_s   = sync_w[1];
    wire en_s    = sync_w[2];

    // ===========================================================
    // Set point from strapped range and set dial
    // Range strap picks the full scale in ticks
    reg [CW-1:0] fs_w;
    always @* begin
        case (range_sel)
            `MDT_RANGE_1S:   fs_w = FS_1S[CW-1:0];
            `MDT_RANGE_10S:  fs_w = FS_10S[CW-1:0];
            `MDT_RANGE_1MIN: fs_w = FS_1MIN[CW-1:0];
            default:         fs_w = FS_10MIN[CW-1:0];
        endcase
    end

    wire [PW-1:0] prod_w = fs_w * set_permille;
    wire [PW-1:0] div_w  = prod_w / SET_FULL;
    // Zero dial still waits one tick so the output never glitches
    wire [CW-1:0] set_w  = (div_w == {PW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1}
                                                 : div_w[CW-1:0];

    // ===========================================================
    // Time base
    reg  [TW-1:0] pre_q;
    reg  [CW-1:0] cnt_q;
    reg  [1:0]    st_q;
    reg           start_d1_q;
    wire          counting = (st_q == ST_RUN);
    wire          tick     = counting && (pre_q == TICK_LAST);
    wire          reached  = tick && (cnt_q + 1'b1 >= set_w);
    // One-shot is edge started so a held start cannot retrigger
    wire          start_rise = start_s && !start_d1_q;
    // Integrating pause keeps the prescaler phase as well as the count
    wire          hold_int = (mode == `MDT_MODE_INTEGRATE) &&
                             (st_q == ST_HOLD);

    // ===========================================================
    // Status
    assign timing = counting;

    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pre_q <= {TW{1'b0}};
        end else if (ce) begin
            if (hold_int)
                pre_q <= pre_q;
            else if (!counting || tick)
                pre_q <= {TW{1'b0}};
            else
                pre_q <= pre_q + 1'b1;
        end
    end

    // ===========================================================
    // Mode sequencer
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            st_q       <= ST_IDLE;
            cnt_q      <= {CW{1'b0}};
            ctrl_out   <= 1'b0;
            start_d1_q <= 1'b0;
        end else if (ce) begin
            start_d1_q <= start_s;
            case (mode)
            `MDT_MODE_ON_DELAY, `MDT_MODE_INTEGRATE: begin
                if (rst_s) begin
                    st_q     <= ST_IDLE;
                    cnt_q    <= {CW{1'b0}};
                    ctrl_out <= 1'b0;
                end else begin
                    case (st_q)
                    // Runs from power-up; reset input is optional
                    ST_IDLE: st_q <= ST_RUN;
                    ST_RUN: begin
                        if (reached) begin
                            st_q     <= ST_DONE;
                            ctrl_out <= 1'b1;
                        end else begin
                            // A tick on the pausing edge still counts
                            if (tick)
                                cnt_q <= cnt_q + 1'b1;
                            if (mode == `MDT_MODE_INTEGRATE && !en_s)
                                st_q <= ST_HOLD;
                        end
                    end
                    ST_HOLD: if (en_s) st_q <= ST_RUN;
                    // Latched until reset input or power-down
                    ST_DONE: ctrl_out <= 1'b1;
                    default: st_q <= ST_IDLE;
                    endcase
                end
            end
            `MDT_MODE_ONE_SHOT: begin
                case (st_q)
                ST_RUN: begin
                    // Start edges ignored here
                    // Reset aborts only while start is released
                    if (rst_s && !start_s) begin
                        st_q     <= ST_IDLE;
                        cnt_q    <= {CW{1'b0}};
                        ctrl_out <= 1'b0;
                    end else if (reached) begin
                        st_q     <= ST_IDLE;
                        cnt_q    <= {CW{1'b0}};
                        ctrl_out <= 1'b0;
                    end else if (tick) begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    cnt_q <= {CW{1'b0}};
                    if (start_rise) begin
                        st_q     <= ST_RUN;
                        ctrl_out <= 1'b1;
                    end else begin
                        st_q     <= ST_IDLE;
                        ctrl_out <= 1'b0;
                    end
                end
                endcase
            end
            default: begin
                // Off-delay: start arms output, reset release times out
                if (start_s) begin
                    // Count held at zero while start stands
                    ctrl_out <= 1'b1;
                    cnt_q    <= {CW{1'b0}};
                    st_q     <= ST_HOLD;
                end else if (rst_s) begin
                    st_q  <= ctrl_out ? ST_HOLD : ST_IDLE;
                    cnt_q <= {CW{1'b0}};
                end else begin
                    case (st_q)
                    ST_HOLD: st_q <= ST_RUN;
                    ST_RUN: begin
                        if (reached) begin
                            st_q     <= ST_IDLE;
                            cnt_q    <= {CW{1'b0}};
                            ctrl_out <= 1'b0;
                        end else if (tick) begin
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                    default: begin
                        st_q     <= ST_IDLE;
                        ctrl_out <= 1'b0;
                    end
                    endcase
                end
            end
            endcase
        end
    end
endmodule // mdt_timer

/* include/mdt_map.vh */
// Constants for the multimode delay timer
`ifndef MDT_MAP_VH
`define MDT_MAP_VH

// ===========================================================
// Operating modes
`define MDT_MODE_ON_DELAY   2'h0
`define MDT_MODE_INTEGRATE  2'h1
`define MDT_MODE_ONE_SHOT   2'h2
`define MDT_MODE_OFF_DELAY  2'h3

// ===========================================================
// Full-scale range codes
`define MDT_RANGE_1S    2'h0
`define MDT_RANGE_10S   2'h1
`define MDT_RANGE_1MIN  2'h2
`define MDT_RANGE_10MIN 2'h3

// ===========================================================
// Time base
`define MDT_CLK_HZ        10000000
`define MDT_TICK_US       1000
`define MDT_TICK_CYCLES   ((`MDT_CLK_HZ / 1000000) * `MDT_TICK_US)

// Full scale in ticks of the time base (1 ms each)
`define MDT_FS_1S_MS      1000
`define MDT_FS_10S_MS     10000
`define MDT_FS_1MIN_MS    60000
`define MDT_FS_10MIN_MS   600000

// Set-point width in per-mille of full scale
`define MDT_SET_W         10
`define MDT_SET_FULL      1000

`endif

/* design/mdt_sync.v */
// Two-stage input synchroniser, one stage pair per bit
`timescale 1ns/1ps
`include "mdt_map.vh"

module mdt_sync #(
    parameter W = 3
) (
    input  wire         mclk,
    input  wire         nrst,
    input  wire         ce,
    input  wire [W-1:0] din,
    output wire [W-1:0] dout
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg sync_q;
            always @(posedge mclk or negedge nrst) begin
                if (!nrst) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                end else if (ce) begin
                    meta_q <= din[i];
                    sync_q <= meta_q;
                end
            end
            // Only the second stage leaves the block
            assign dout[i] = sync_q;
        end
    endgenerate
endmodule // mdt_sync

/* tb/mdt_switch.sv */
// Clean contact model for the start, reset and enable inputs
`timescale 1ns/1ps
module mdt_switch (
    input  wire       mclk,
    input  wire [2:0] want,
    output reg  [2:0] pins
);
    initial pins = 3'h4;
    // Bounce-free, no leakage: levels move only at the falling edge
    always @(negedge mclk) begin
        pins <= want;
    end
endmodule // mdt_switch

/* tb/mdt_timer_assertions.sv */
// Port-level timing checks for the delay timer
`timescale 1ns/1ps
module mdt_timer_assertions (
    input wire       mclk,
    input wire       nrst,
    input wire [1:0] mode,
    input wire       start_in,
    input wire       reset_in,
    input wire       run_en,
    input wire       ctrl_out,
    input wire       timing
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    a_rst_clears_out: assert property (
        $rose(nrst) |-> !ctrl_out && !timing)
        else $error("output set at reset release");
    a_on_reset: assert property (
        (!mode[1] && reset_in)[*4] |-> !ctrl_out)
        else $error("reset input left output set");
    a_on_keep: assert property (
        (!mode[1] && !reset_in)[*4] ##0 ctrl_out |=> ctrl_out)
        else $error("delay output dropped");
    a_int_pause: assert property (
        (mode == 2'h1 && !run_en)[*4] |=> !$rose(ctrl_out))
        else $error("output rose while paused");
    a_os_start: assert property (
        mode == 2'h2 && $rose(start_in) && !timing && !reset_in
        |-> ##[1:4] ctrl_out)
        else $error("one-shot output late");
    a_os_end: assert property (
        mode == 2'h2 && $fell(timing) |-> ##[0:1] !ctrl_out)
        else $error("one-shot output stuck");
    a_od_start: assert property (
        mode == 2'h3 && start_in |-> ##[1:4] ctrl_out)
        else $error("off-delay output late");
    a_od_hold: assert property (
        (mode == 2'h3 && reset_in)[*5] ##0 ctrl_out |=> ctrl_out)
        else $error("off-delay timed under reset");
    c_on: cover property (!mode[1] && $rose(ctrl_out));
    c_os: cover property (mode == 2'h2 && $fell(ctrl_out));
    c_od: cover property (mode == 2'h3 && $fell(ctrl_out));
endmodule // mdt_timer_assertions

/* tb/test_multimode_delay_timer.sv */
// Self-checking bench for the multimode delay timer
`timescale 1ns/1ps
module test_multimode_delay_timer;
    localparam TK = 10;
    reg        mclk = 1'b0;
    reg        nrst = 1'b0;
    reg        ce   = 1'b1;
    reg  [1:0] mode = 2'h0;
    reg  [1:0] rng  = 2'h0;
    reg  [9:0] sp   = 10'h3e8;
    reg  [2:0] want = 3'h4; // run_en, reset_in, start_in
    wire [2:0] pins;
    wire       ctrl_out;
    wire       timing;
    integer    seed = 32'h69b043f3;
    integer    miscompares = 0;
    integer    comparisons = 0;
    integer    cyc = 0;
    integer    n, t, t2;
    integer    fs_q[$] = '{10, 20, 30, 40};
    always #50 mclk = ~mclk;
    mdt_switch sw (.mclk(mclk), .want(want), .pins(pins));
    mdt_timer #(.TICK_CYCLES(TK), .FS_1S(10), .FS_10S(20), .FS_1MIN(30),
        .FS_10MIN(40)) dut (.mclk(mclk), .nrst(nrst), .ce(ce),
        .mode(mode), .range_sel(rng), .set_permille(sp),
        .start_in(pins[0]), .reset_in(pins[1]), .run_en(pins[2]),
        .ctrl_out(ctrl_out), .timing(timing));
    task results;
        if (miscompares == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] expv, input string what);
        comparisons = comparisons + 1;
        if (seen !== expv) begin
            miscompares = miscompares + 1;
            $display("mismatch %s expected %0d seen %0d", what, expv, seen);
        end
    endtask
    // Tick phase is free, so allow one tick plus the synchroniser
    function bit near(input integer s, input integer e);
        near = s > e - TK - 1 && s < e + TK + 5;
    endfunction
    task restart(input [1:0] m);
        @(negedge mclk);
        nrst = 1'b0;
        mode = m;
        want = 3'h4;
        rng = $random(seed);
        sp = 10'h1f4 + {$random(seed)} % 501;
        n = fs_q[rng] * sp / 1000;
        repeat (3) @(negedge mclk);
        check(ctrl_out, 0, "out in reset");
        nrst = 1'b1;
    endtask
    task wait_out(input v, input integer lim, output integer c);
        c = 0;
        while (ctrl_out !== v && c < lim) begin
            @(negedge mclk);
            c = c + 1;
        end
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            miscompares = miscompares + 1;
            results;
        end
    end
    initial begin
        restart(2'h0);
        wait_out(1'b1, 2000, t);
        check(near(t, n * TK), 1, "on delay");
        want[1] = 1'b1;
        repeat (5) @(negedge mclk);
        check(ctrl_out, 0, "on reset");
        check(timing, 0, "reset timing");
        want[1] = 1'b0;
        wait_out(1'b1, 2000, t);
        check(near(t, n * TK), 1, "on retime");
        restart(2'h1);
        repeat (n * TK / 2) @(negedge mclk);
        want[2] = 1'b0;
        repeat (300) @(negedge mclk);
        check(ctrl_out, 0, "paused");
        check(timing, 0, "pause timing");
        want[2] = 1'b1;
        wait_out(1'b1, 2000, t);
        check(near(t + n * TK / 2, n * TK), 1, "sum");
        restart(2'h2);
        repeat (20) @(negedge mclk);
        check(ctrl_out, 0, "no start");
        want[0] = 1'b1;
        wait_out(1'b1, 6, t);
        check(t < 6, 1, "shot start");
        check(timing, 1, "shot timing");
        want[0] = 1'b0;
        repeat (20) @(negedge mclk);
        want[0] = 1'b1;
        repeat (5) @(negedge mclk);
        want[0] = 1'b0;
        // Clock enable low must stretch the shot by the frozen cycles
        ce = 1'b0;
        repeat (100) @(negedge mclk);
        check(ctrl_out, 1, "frozen out");
        check(timing, 1, "frozen run");
        ce = 1'b1;
        wait_out(1'b0, 2000, t2);
        check(near(t + t2 + 125, n * TK + 100), 1, "shot len");
        check(timing, 0, "shot over");
        repeat (5) @(negedge mclk);
        want[0] = 1'b1;
        wait_out(1'b1, 6, t);
        want = 3'h6;
        wait_out(1'b0, 6, t);
        check(t < 6, 1, "abort");
        restart(2'h3);
        want[1] = 1'b1;
        repeat (5) @(negedge mclk);
        want[0] = 1'b1;
        wait_out(1'b1, 6, t);
        check(t < 6, 1, "off start");
        want[0] = 1'b0;
        repeat (n * TK + 50) @(negedge mclk);
        check(ctrl_out, 1, "held");
        check(timing, 0, "held timing");
        want[1] = 1'b0;
        wait_out(1'b0, 2000, t);
        check(near(t, n * TK), 1, "off delay");
        results;
    end
endmodule // test_multimode_delay_timer
bind mdt_timer mdt_timer_assertions chk (.mclk(mclk), .nrst(nrst),
    .mode(mode), .start_in(start_in), .reset_in(reset_in),
    .run_en(run_en), .ctrl_out(ctrl_out), .timing(timing));
